// [hdl/miau_defs.vh]
// constants for the maskable interrupt acceptance unit
`ifndef MIAU_DEFS_VH
`define MIAU_DEFS_VH
// apb register byte offsets
`define MIAU_OFS_CTRL 12'h000
`define MIAU_OFS_PEND 12'h004
`define MIAU_OFS_PRI0 12'h008
`define MIAU_OFS_PRI1 12'h00C
`define MIAU_OFS_SEL1 12'h010
`define MIAU_OFS_STAT 12'h014
`define MIAU_OFS_FLAG 12'h018
`define MIAU_OFS_PC 12'h01C
`define MIAU_OFS_SP 12'h020
`define MIAU_OFS_VBASE 12'h024
`define MIAU_OFS_SWI 12'h028
`define MIAU_OFS_EVT 12'h02C
// flag register bit positions
`define MIAU_FLAG_D 2
`define MIAU_FLAG_U 7
`define MIAU_FLAG_I 6
// control register bits
`define MIAU_CTRL_BOUND 0
`define MIAU_CTRL_RET 1
// source-select register 1 fields
`define MIAU_SEL_SLOT9 6
`define MIAU_SEL_SLOT8 7
// special request bits in event register
`define MIAU_EVT_OSC 0
`define MIAU_EVT_WDT 1
`define MIAU_EVT_NMI 2
`define MIAU_EVT_DBG 3
`define MIAU_EVT_STEP 4
// reset values
`define MIAU_RST_FLAG 16'h0000
`define MIAU_RST_SP 20'h0_0400
`define MIAU_RST_VBASE 20'h0_0000
// fixed vector addresses of special sources
`define MIAU_VEC_OSC 20'hF_FFF0
`define MIAU_VEC_NMI 20'hF_FFF8
`define MIAU_VEC_DBG 20'hF_FFF4
`define MIAU_VEC_STEP 20'hF_FFEC
// level and slot numbers
`define MIAU_LVL_MAX 3'h7
`define MIAU_SLOT8 5'h08
`define MIAU_SLOT9 5'h09
`define MIAU_SWI_U_LO 6'h20
`define MIAU_VEC_BYTES 20'h0_0004
`endif

// [hdl/miau_core.v]
// maskable interrupt acceptance and entry sequencer with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "miau_defs.vh"
module miau_core (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // peripheral request strobes, one per slot 0..31 (same clock)
    input wire [31:0] periph_req,
    // external edge sources; 0..3 take slots 29..31 and 4, 4 and 5 share slots 9 and 8
    input wire [5:0] external_edge_irq,
    // cpu core side
    input wire insn_boundary,
    input wire repeat_op_active,
    // memory bus for acknowledge, stacking and vector fetch
    output reg mem_req,
    output reg mem_we,
    output reg mem_byte,
    output reg [19:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire mem_ack,
    // sequencer status
    output wire entry_busy,
    output reg [19:0] pc_out
);
    localparam ST_IDLE = 4'h0;
    localparam ST_ACK = 4'h1;
    localparam ST_PUSH1 = 4'h2;
    localparam ST_PUSH2 = 4'h3;
    localparam ST_VEC_L = 4'h4;
    localparam ST_VEC_H = 4'h5;
    localparam ST_POP1 = 4'h6;
    localparam ST_POP2 = 4'h7;

    reg [3:0] state_reg;
    reg [31:0] pend_reg;
    reg [95:0] pri_reg;
    reg [7:0] sel1_reg;
    reg [15:0] flag_reg;
    reg [2:0] plvl_reg;
    reg [19:0] pc_reg;
    reg [19:0] istk_reg;
    reg [19:0] usp_reg;
    reg [19:0] vbase_reg;
    reg [15:0] tmp_flag_reg;
    reg [5:0] num_reg;
    reg [2:0] new_plvl_reg;
    reg keep_plvl_reg;
    reg use_usp_reg;
    reg odd_reg;
    reg half_reg;
    reg [19:0] vec_addr_reg;
    reg [15:0] word_reg;
    reg [4:0] evt_reg;
    reg [5:0] swi_num_reg;
    reg swi_req_reg;
    reg [1:0] ctrl_reg;
    reg [5:0] ext_prev_reg;
    reg [19:0] pop_pc_reg;

    wire wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign entry_busy = (state_reg != ST_IDLE);

    // edge detection on external inputs; both-edge or falling, per select bit
    wire [5:0] ext_rise = external_edge_irq & ~ext_prev_reg;
    wire [5:0] ext_fall = ~external_edge_irq & ext_prev_reg;
    wire [5:0] ext_edge = ext_fall | (ext_rise & sel1_reg[5:0]);

    // slot routing; slots 29..31 and 4 take ext 0..3
    reg [31:0] req_vec;
    always @* begin
        req_vec = periph_req;
        req_vec[29] = ext_edge[0];
        req_vec[30] = ext_edge[1];
        req_vec[31] = ext_edge[2];
        req_vec[4] = ext_edge[3];
        if (sel1_reg[`MIAU_SEL_SLOT9])
            req_vec[9] = ext_edge[4];
        if (sel1_reg[`MIAU_SEL_SLOT8])
            req_vec[8] = ext_edge[5];
    end

    // static resolution: highest level, lowest slot on ties
    reg [2:0] best_lvl;
    reg [4:0] best_src;
    reg best_ok;
    integer i;
    always @* begin
        best_lvl = 3'h0;
        best_src = 5'h00;
        best_ok = 1'b0;
        for (i = 31; i >= 0; i = i - 1) begin
            if (pend_reg[i] && pri_reg[i*3 +: 3] != 3'h0
                && pri_reg[i*3 +: 3] > plvl_reg
                && pri_reg[i*3 +: 3] >= best_lvl) begin
                best_lvl = pri_reg[i*3 +: 3];
                best_src = i[4:0];
                best_ok = 1'b1;
            end
        end
    end

    wire take_point = insn_boundary || repeat_op_active;
    wire mask_ok = best_ok && flag_reg[`MIAU_FLAG_I];
    wire special = |evt_reg[2:0];
    wire cur_sp_odd = use_usp_reg ? usp_reg[0] : istk_reg[0];
    wire [19:0] cur_sp = use_usp_reg ? usp_reg : istk_reg;
    wire [15:0] push_item1 = {pc_reg[19:16], 1'b0, plvl_reg, flag_reg[7:0]};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            pend_reg <= 32'h0000_0000;
            pri_reg <= 96'h0;
            sel1_reg <= 8'h00;
            flag_reg <= `MIAU_RST_FLAG;
            plvl_reg <= 3'h0;
            pc_reg <= 20'h0_0000;
            istk_reg <= `MIAU_RST_SP;
            usp_reg <= `MIAU_RST_SP;
            vbase_reg <= `MIAU_RST_VBASE;
            tmp_flag_reg <= 16'h0000;
            num_reg <= 6'h00;
            new_plvl_reg <= 3'h0;
            keep_plvl_reg <= 1'b0;
            use_usp_reg <= 1'b0;
            odd_reg <= 1'b0;
            half_reg <= 1'b0;
            vec_addr_reg <= 20'h0_0000;
            word_reg <= 16'h0000;
            evt_reg <= 5'h00;
            swi_num_reg <= 6'h00;
            swi_req_reg <= 1'b0;
            ctrl_reg <= 2'h0;
            ext_prev_reg <= 6'h00;
            pop_pc_reg <= 20'h0_0000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_byte <= 1'b0;
            mem_addr <= 20'h0_0000;
            mem_wdata <= 16'h0000;
            pc_out <= 20'h0_0000;
        end else begin
            ext_prev_reg <= external_edge_irq;
            pc_out <= pc_reg;
            // software writes; the sp write loads both stack pointers, the flag write also loads the level
            if (wr_en) begin
                case (paddr)
                `MIAU_OFS_PEND: pend_reg <= pend_reg & pwdata;
                `MIAU_OFS_PRI0: pri_reg[47:0] <= {pri_reg[47:32], pwdata};
                `MIAU_OFS_PRI1: pri_reg[95:48] <= {pwdata, pri_reg[63:48]};
                `MIAU_OFS_SEL1: sel1_reg <= pwdata[7:0];
                `MIAU_OFS_FLAG: begin
                    flag_reg <= pwdata[15:0];
                    plvl_reg <= pwdata[14:12];
                end
                `MIAU_OFS_PC: pc_reg <= pwdata[19:0];
                `MIAU_OFS_SP: begin
                    istk_reg <= pwdata[19:0];
                    usp_reg <= pwdata[19:0];
                end
                `MIAU_OFS_VBASE: vbase_reg <= pwdata[19:0];
                `MIAU_OFS_SWI: begin
                    swi_num_reg <= pwdata[5:0];
                    swi_req_reg <= 1'b1;
                end
                `MIAU_OFS_EVT: evt_reg <= evt_reg | pwdata[4:0];
                `MIAU_OFS_CTRL: ctrl_reg <= pwdata[1:0];
                default: ;
                endcase
            end
            // hardware set wins over a same-cycle software clear
            pend_reg <= (wr_en && paddr == `MIAU_OFS_PEND ? pend_reg & pwdata : pend_reg)
                        | req_vec;
            case (state_reg)
            ST_IDLE: begin
                if (swi_req_reg) begin
                    swi_req_reg <= 1'b0;
                    num_reg <= swi_num_reg;
                    keep_plvl_reg <= 1'b1;
                    use_usp_reg <= (swi_num_reg >= `MIAU_SWI_U_LO)
                                   && flag_reg[`MIAU_FLAG_U];
                    vec_addr_reg <= vbase_reg + {12'h000, swi_num_reg, 2'b00};
                    state_reg <= ST_ACK;
                end else if (take_point && (special || mask_ok)) begin
                    use_usp_reg <= 1'b0;
                    if (special) begin
                        keep_plvl_reg <= 1'b0;
                        new_plvl_reg <= `MIAU_LVL_MAX;
                        vec_addr_reg <= evt_reg[2] ? `MIAU_VEC_NMI : `MIAU_VEC_OSC;
                        evt_reg[2:0] <= evt_reg[2] ? (evt_reg[2:0] & 3'b011) : 3'b000;
                        num_reg <= 6'h3F;
                    end else begin
                        keep_plvl_reg <= 1'b0;
                        new_plvl_reg <= best_lvl;
                        num_reg <= {1'b0, best_src};
                        vec_addr_reg <= vbase_reg + {13'h0000, best_src, 2'b00};
                    end
                    state_reg <= ST_ACK;
                end else if (ctrl_reg[`MIAU_CTRL_RET]) begin
                    ctrl_reg[`MIAU_CTRL_RET] <= 1'b0;
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_byte <= 1'b0;
                    mem_addr <= istk_reg;
                    state_reg <= ST_POP1;
                end
            end
            ST_ACK: begin
                // acknowledge read at address zero
                if (!mem_req) begin
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_byte <= 1'b0;
                    mem_addr <= 20'h0_0000;
                end else if (mem_ack) begin
                    if (num_reg < 6'h20)
                        pend_reg[num_reg[4:0]] <= 1'b0;
                    tmp_flag_reg <= flag_reg;
                    flag_reg[`MIAU_FLAG_I] <= 1'b0;
                    flag_reg[`MIAU_FLAG_D] <= 1'b0;
                    if (!(keep_plvl_reg && num_reg >= `MIAU_SWI_U_LO))
                        flag_reg[`MIAU_FLAG_U] <= 1'b0;
                    odd_reg <= cur_sp_odd;
                    half_reg <= 1'b0;
                    mem_we <= 1'b1;
                    mem_byte <= cur_sp_odd;
                    mem_addr <= cur_sp - (cur_sp_odd ? 20'h0_0001 : 20'h0_0002);
                    word_reg <= push_item1;
                    // odd stack sends the high byte first; data must stand with the address
                    mem_wdata <= cur_sp_odd ? {8'h00, push_item1[15:8]} : push_item1;
                    state_reg <= ST_PUSH1;
                end
            end
            ST_PUSH1, ST_PUSH2: begin
                if (mem_ack) begin
                    if (odd_reg && !half_reg) begin
                        // odd stack: second byte of the same item
                        half_reg <= 1'b1;
                        mem_addr <= mem_addr - 20'h0_0001;
                        mem_wdata <= {8'h00, word_reg[7:0]};
                    end else if (state_reg == ST_PUSH1) begin
                        half_reg <= 1'b0;
                        mem_addr <= mem_addr - (odd_reg ? 20'h0_0001 : 20'h0_0002);
                        word_reg <= pc_reg[15:0];
                        mem_wdata <= odd_reg ? {8'h00, pc_reg[15:8]} : pc_reg[15:0];
                        state_reg <= ST_PUSH2;
                    end else begin
                        if (use_usp_reg)
                            usp_reg <= mem_addr;
                        else
                            istk_reg <= mem_addr;
                        if (!keep_plvl_reg)
                            plvl_reg <= new_plvl_reg;
                        mem_we <= 1'b0;
                        mem_byte <= 1'b0;
                        mem_addr <= vec_addr_reg;
                        state_reg <= ST_VEC_L;
                    end
                end
            end
            ST_VEC_L: begin
                if (mem_ack) begin
                    pc_reg[15:0] <= mem_rdata;
                    mem_addr <= vec_addr_reg + 20'h0_0002;
                    state_reg <= ST_VEC_H;
                end
            end
            ST_VEC_H: begin
                if (mem_ack) begin
                    pc_reg[19:16] <= mem_rdata[3:0];
                    mem_req <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            ST_POP1: begin
                if (mem_ack) begin
                    pop_pc_reg[15:0] <= mem_rdata;
                    mem_addr <= istk_reg + 20'h0_0002;
                    state_reg <= ST_POP2;
                end
            end
            ST_POP2: begin
                if (mem_ack) begin
                    // flag low byte, level and pc restored from the interrupt stack
                    flag_reg[7:0] <= mem_rdata[7:0];
                    plvl_reg <= mem_rdata[10:8];
                    pc_reg <= {mem_rdata[15:12], pop_pc_reg[15:0]};
                    istk_reg <= istk_reg + 20'h0_0004;
                    mem_req <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // register readback shows live sequencer state
    always @* begin
        case (paddr)
        `MIAU_OFS_CTRL: prdata = {30'h0, ctrl_reg};
        `MIAU_OFS_PEND: prdata = pend_reg;
        `MIAU_OFS_PRI0: prdata = pri_reg[31:0];
        `MIAU_OFS_PRI1: prdata = pri_reg[79:48];
        `MIAU_OFS_SEL1: prdata = {24'h0, sel1_reg};
        `MIAU_OFS_STAT: prdata = {16'h0, num_reg, plvl_reg, 3'h0, state_reg};
        `MIAU_OFS_FLAG: prdata = {16'h0, 1'b0, plvl_reg, flag_reg[11:0]};
        `MIAU_OFS_PC: prdata = {12'h0, pc_reg};
        `MIAU_OFS_SP: prdata = {12'h0, istk_reg};
        `MIAU_OFS_VBASE: prdata = {12'h0, vbase_reg};
        `MIAU_OFS_EVT: prdata = {27'h0, evt_reg};
        default: prdata = 32'h0000_0000;
        endcase
    end
endmodule // miau_core
`default_nettype wire

// [tb/miau_core_checker.sv]
// checker for the entry and return memory sequences
`timescale 1ns/1ps
`default_nettype none
module miau_core_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // memory side of the sequencer
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_byte,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic entry_busy,
    input wire logic [19:0] pc_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] wr_cnt, rd_cnt;
    logic [19:0] last_wr, last_rd;
    logic [15:0] cur_rd, prev_rd;
    wire wr_ack = mem_req && mem_ack && mem_we;
    wire rd_ack = mem_req && mem_ack && !mem_we;
    // counters restart whenever the sequencer is idle; read data is kept for the pc checks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_cnt <= 4'h0;
            rd_cnt <= 4'h0;
            last_wr <= 20'h0_0000;
            last_rd <= 20'h0_0000;
            cur_rd <= 16'h0000;
            prev_rd <= 16'h0000;
        end else begin
            wr_cnt <= !entry_busy ? 4'h0 : wr_cnt + {3'h0, wr_ack};
            rd_cnt <= !entry_busy ? 4'h0 : rd_cnt + {3'h0, rd_ack};
            if (wr_ack) last_wr <= mem_addr;
            if (rd_ack) begin
                last_rd <= mem_addr;
                prev_rd <= cur_rd;
                cur_rd <= mem_rdata;
            end
        end
    end
    a_odd_write_byte: assert property (mem_req && mem_we && mem_addr[0] |-> mem_byte)
        else $error("word write at odd stack address");
    a_busy_covers_req: assert property (mem_req |-> entry_busy)
        else $error("memory request outside a sequence");
    a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before its answer");
    a_ack_then_push: assert property (rd_ack && mem_addr == 20'h0_0000 |-> ##[1:4] (mem_req && mem_we))
        else $error("no stacking after acknowledge read");
    a_item_then_pc: assert property (wr_ack && !mem_byte && wr_cnt == 4'h1 |-> mem_addr == last_wr - 20'h0_0002)
        else $error("pc low not stacked below first item");
    a_vec_halves: assert property (rd_ack && rd_cnt != 4'h0 && last_rd != 20'h0_0000 |-> mem_addr == last_rd + 20'h0_0002)
        else $error("second half not read from next word");
    a_pc_from_vec: assert property ($fell(entry_busy) && wr_cnt != 4'h0 |-> ##[0:2] pc_out == {cur_rd[3:0], prev_rd})
        else $error("pc not loaded from vector entry");
    a_return_pc: assert property ($fell(entry_busy) && wr_cnt == 4'h0 && rd_cnt == 4'h2 |-> ##[0:2] pc_out == {cur_rd[15:12], prev_rd})
        else $error("pc not restored from stack");
endmodule // miau_core_checker
bind miau_core miau_core_checker miau_core_checker_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .entry_busy(entry_busy), .pc_out(pc_out));
`default_nettype wire

// [tb/miau_mem_model.sv]
// memory partner answering acknowledge, stacking and vector cycles
`timescale 1ns/1ps
`default_nettype none
module miau_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the sequencer
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_byte,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    // answer
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [int];
    logic [1:0] wait_cnt, gap;
    // unwritten bytes read as address low byte xor a5, so every vector differs
    function automatic logic [7:0] rdb(input int a);
        return mem.exists(a) ? mem[a] : (8'(a) ^ 8'ha5);
    endfunction
    // answer delay cycles 0,1,2 so both prompt and slow answers occur
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_cnt <= 2'h0;
            gap <= 2'h0;
        end else if (mem_ack || !mem_req || wait_cnt != 2'h0) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (!mem_ack && mem_req) wait_cnt <= wait_cnt - 2'h1;
        end else begin
            mem_ack <= 1'b1;
            gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
            wait_cnt <= gap;
            if (mem_we) begin
                mem[int'(mem_addr)] = mem_wdata[7:0];
                if (!mem_byte) mem[int'(mem_addr) + 1] = mem_wdata[15:8];
            end else begin
                mem_rdata <= {rdb(int'(mem_addr) + 1), rdb(int'(mem_addr))};
            end
        end
    end
endmodule // miau_mem_model
`default_nettype wire

// [tb/test_maskable_interrupt_acceptance_unit.sv]
// self-checking bench for the interrupt acceptance unit
`timescale 1ns/1ps
`default_nettype none
`include "miau_defs.vh"
module test_maskable_interrupt_acceptance_unit;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, periph_req;
    logic [5:0] ext;
    logic insn_boundary, repeat_op_active, mem_req, mem_we, mem_byte, mem_ack, entry_busy;
    logic [19:0] mem_addr, pc_out, vb, pcv;
    logic [15:0] mem_wdata, mem_rdata;
    int n_mismatch, comparisons, i;
    int seed = 32'hec48d470;
    int slot_of[6] = '{29, 30, 31, 4, 9, 8};
    logic [31:0] rd_q[$];
    logic [36:0] mem_q[$];
    miau_core miau_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .external_edge_irq(ext),
        .insn_boundary(insn_boundary), .repeat_op_active(repeat_op_active), .mem_req(mem_req),
        .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .entry_busy(entry_busy), .pc_out(pc_out));
    miau_mem_model miau_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_mem(input string what, input logic [36:0] e, input logic [36:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic pulse(input logic [31:0] m);
        periph_req <= m;
        @(posedge pclk);
        periph_req <= 32'h0000_0000;
    endtask
    // reads carry no write data, so it is compared as zero
    task automatic entry(input logic [19:0] sp, input logic [15:0] item, input logic [15:0] pclo,
                         input logic [19:0] vo);
        mem_q.push_back({1'b0, 20'h0_0000, 16'h0000});
        mem_q.push_back({1'b1, sp - 20'h0_0002, item});
        mem_q.push_back({1'b1, sp - 20'h0_0004, pclo});
        mem_q.push_back({1'b0, vb + vo, 16'h0000});
        mem_q.push_back({1'b0, vb + vo + 20'h0_0002, 16'h0000});
    endtask
    task automatic settle;
        int k;
        k = 0;
        repeat (4) @(posedge pclk);
        while ((entry_busy !== 1'b0 || mem_q.size() != 0) && k < 200) begin
            @(posedge pclk);
            k++;
        end
        if (k == 200) chk32("sequence end", 32'h0000_0000, 32'h0000_0001);
    endtask
    function automatic logic [19:0] vec_pc(input logic [19:0] v);
        logic [7:0] b2;
        b2 = (v[7:0] + 8'h02) ^ 8'ha5;
        return {b2[3:0], (v[7:0] + 8'h01) ^ 8'ha5, v[7:0] ^ 8'ha5};
    endfunction
    always @(posedge pclk) begin
        if (presetn && mem_req === 1'b1 && mem_ack === 1'b1) begin
            if (mem_q.size() == 0) chk_mem("memory transfer", 37'h1f_ffff_ffff, {mem_we, mem_addr, mem_wdata});
            else chk_mem("memory transfer", mem_q.pop_front(), {mem_we, mem_addr, mem_we ? mem_wdata : 16'h0000});
        end
        if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() != 0) chk32("read data", rd_q.pop_front(), prdata);
        if (psel && penable && pready === 1'b1) chk32("bus error", 32'h0000_0000, {31'h0, pslverr});
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #80000;
        chk32("run length", 32'h0000_0000, 32'h0000_0001);
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, insn_boundary, repeat_op_active} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        periph_req = 32'h0000_0000;
        ext = 6'h00;
        vb = 20'($random(seed)) & 20'hf_ff00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        insn_boundary <= 1'b1;
        rd(`MIAU_OFS_FLAG, {16'h0000, `MIAU_RST_FLAG});
        rd(`MIAU_OFS_SP, {12'h000, `MIAU_RST_SP});
        wr(`MIAU_OFS_PRI0, 32'h0000_0a00);
        wr(`MIAU_OFS_VBASE, {12'h000, vb});
        rd(`MIAU_OFS_PRI0, 32'h0000_0a00);
        pulse(32'h0000_0008);
        rd(`MIAU_OFS_PEND, 32'h0000_0008);
        entry(20'h0_0400, 16'h0040, 16'h0000, 20'h0_000c);
        wr(`MIAU_OFS_FLAG, 32'h0000_0040);
        settle();
        rd(`MIAU_OFS_FLAG, 32'h0000_5000);
        rd(`MIAU_OFS_PEND, 32'h0000_0000);
        rd(`MIAU_OFS_PC, {12'h000, vec_pc(vb + 20'h0_000c)});
        mem_q.push_back({1'b0, 20'h0_03fc, 16'h0000});
        mem_q.push_back({1'b0, 20'h0_03fe, 16'h0000});
        wr(`MIAU_OFS_CTRL, 32'h0000_0002);
        settle();
        rd(`MIAU_OFS_FLAG, 32'h0000_0040);
        rd(`MIAU_OFS_PC, 32'h0000_0000);
        $display("accept and return test done");
        wr(`MIAU_OFS_FLAG, 32'h0000_4040);
        wr(`MIAU_OFS_PRI0, 32'h0000_0120);
        pulse(32'h0000_000e);
        settle();
        rd(`MIAU_OFS_PEND, 32'h0000_000e);
        entry(20'h0_0400, 16'h0340, 16'h0000, 20'h0_0004);
        wr(`MIAU_OFS_FLAG, 32'h0000_3040);
        settle();
        rd(`MIAU_OFS_PEND, 32'h0000_000c);
        rd(`MIAU_OFS_FLAG, 32'h0000_4000);
        pcv = vec_pc(vb + 20'h0_0004);
        entry(20'h0_03fc, {pcv[19:16], 12'h400}, pcv[15:0], 20'h0_00a0);
        wr(`MIAU_OFS_SWI, 32'h0000_0028);
        settle();
        rd(`MIAU_OFS_FLAG, 32'h0000_4000);
        pcv = vec_pc(vb + 20'h0_00a0);
        entry(20'h0_03f8, {pcv[19:16], 12'h400}, pcv[15:0], 20'hf_fff8 - vb);
        insn_boundary <= 1'b0;
        wr(`MIAU_OFS_EVT, 32'h0000_0004);
        rd(`MIAU_OFS_EVT, 32'h0000_0004);
        repeat_op_active <= 1'b1;
        settle();
        {insn_boundary, repeat_op_active} <= 2'b10;
        rd(`MIAU_OFS_EVT, 32'h0000_0000);
        rd(`MIAU_OFS_FLAG, 32'h0000_7000);
        pcv = vec_pc(20'hf_fff8);
        wr(`MIAU_OFS_SP, 32'h0000_03f1);
        mem_q.push_back({1'b0, 20'h0_0000, 16'h0000});
        mem_q.push_back({1'b1, 20'h0_03f0, 8'h00, pcv[19:16], 4'h7});
        mem_q.push_back({1'b1, 20'h0_03ef, 16'h0000});
        mem_q.push_back({1'b1, 20'h0_03ee, 8'h00, pcv[15:8]});
        mem_q.push_back({1'b1, 20'h0_03ed, 8'h00, pcv[7:0]});
        mem_q.push_back({1'b0, vb + 20'h0_0084, 16'h0000});
        mem_q.push_back({1'b0, vb + 20'h0_0086, 16'h0000});
        wr(`MIAU_OFS_SWI, 32'h0000_0021);
        settle();
        rd(`MIAU_OFS_SP, 32'h0000_03ed);
        $display("special and odd stack test done");
        $display("priority and software entry test done");
        wr(`MIAU_OFS_SEL1, 32'h0000_00c0);
        for (i = 0; i < 6; i++) begin
            wr(`MIAU_OFS_PEND, 32'h0000_0000);
            ext[i] <= 1'b1;
            @(posedge pclk);
            ext[i] <= 1'b0;
            @(posedge pclk);
            rd(`MIAU_OFS_PEND, 32'h0000_0001 << slot_of[i]);
        end
        wr(`MIAU_OFS_SEL1, 32'h0000_0001);
        wr(`MIAU_OFS_PEND, 32'h0000_0000);
        ext[0] <= 1'b1;
        @(posedge pclk);
        rd(`MIAU_OFS_PEND, 32'h2000_0000);
        ext[0] <= 1'b0;
        wr(`MIAU_OFS_SEL1, 32'h0000_0000);
        wr(`MIAU_OFS_PEND, 32'h0000_0000);
        pulse(32'h0000_0000);
        ext[4] <= 1'b1;
        @(posedge pclk);
        ext[4] <= 1'b0;
        @(posedge pclk);
        rd(`MIAU_OFS_PEND, 32'h0000_0000);
        $display("edge input test done");
        wrap_up();
    end
endmodule // test_maskable_interrupt_acceptance_unit
`default_nettype wire
